/* inc/sic_defines.vh */
// Purpose: Constants for the start-up and mode control block.
// Assumes: 20 MHz clock, 50 ns period.
// Notes:   Times are in microseconds; cycle counts derive from them.
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH

`define SIC_CLK_MHZ            20
`define SIC_CFG_FILT_US        10
`define SIC_CFG_FILT_CYC       (`SIC_CFG_FILT_US * `SIC_CLK_MHZ)
`define SIC_RST_DELAY_US       100
`define SIC_RST_DELAY_CYC      (`SIC_RST_DELAY_US * `SIC_CLK_MHZ)
`define SIC_LONG_WIN_US        200000
`define SIC_LONG_WIN_CYC       (`SIC_LONG_WIN_US * `SIC_CLK_MHZ)

`define SIC_MODE_W             3
`define SIC_MODE_NORMAL        3'h0
`define SIC_MODE_STOP          3'h1
`define SIC_MODE_SLEEP         3'h2
`define SIC_MODE_RESTART       3'h3
`define SIC_MODE_FAILSAFE      3'h4
`define SIC_MODE_INIT          3'h5

`define SIC_CAN_OFF            2'h0
`define SIC_CAN_WAKE           2'h1

`endif

/* logic/sic_strap_filter.v */
// Purpose: Continuous filter on the synchronised strap level.
// Assumes: Input already passed a two-stage synchroniser.
// Notes:   High only after the input stayed high the full filter time.
`timescale 1ns/1ns
`default_nettype none
module sic_strap_filter
#(
	parameter CNT_W = 16,
	parameter [CNT_W-1:0] FILT_CYC = 16'd200
)
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Control
	input  wire       clr_i,
	input  wire       lvl_i,
	// Result
	output reg        stable_hi_o
);
	reg [CNT_W-1:0] cnt_q;

	always @(posedge clk_i)
	begin
		if (rst_i || clr_i || !lvl_i)
		begin
			cnt_q       <= {CNT_W{1'b0}};
			stable_hi_o <= 1'b0;
		end
		else if (cnt_q == FILT_CYC - 1'b1)
		begin
			stable_hi_o <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // sic_strap_filter
`default_nettype wire

/* logic/sic_init_ctrl.v */
// Purpose: Start-up, strap capture and mode control of a basis chip.
// Assumes: Analog comparators and serial decoder supply level inputs
//          and one-cycle pulses on clk_i; pins are asynchronous.
// Notes:   Restart holds the reset output low for the reset delay.
`timescale 1ns/1ns
`default_nettype none
`include "sic_defines.vh"
module sic_init_ctrl
#(
	parameter [31:0] LONG_WIN_CYC  = `SIC_LONG_WIN_CYC,
	parameter [15:0] RST_DELAY_CYC = `SIC_RST_DELAY_CYC,
	parameter [15:0] CFG_FILT_CYC  = `SIC_CFG_FILT_CYC
)
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Supply monitors
	input  wire       por_ok_i,
	input  wire       main_reg_ok_i,
	input  wire       main_reg_ov_i,
	// Pins
	input  wire       irq_pin_i,
	input  wire       debug_strap_pin_i,
	output reg        irq_o,
	output wire       irq_oe_n_o,
	output reg        reset_output_pin_o,
	output reg        fail_outputs_o,
	// Serial command decoder
	input  wire       cmd_rx_i,
	input  wire       cmd_mode_wr_i,
	input  wire [2:0] cmd_mode_i,
	input  wire       wd_trigger_i,
	input  wire       wd_fail_i,
	input  wire       wake_evt_i,
	// Control bits
	input  wire       por_flag_clr_i,
	input  wire       fail_cnt_sel_i,
	input  wire       overvoltage_reset_enable_i,
	input  wire       fail_output_test_enable_i,
	input  wire       ov_flag_clr_i,
	input  wire       aux_reg_en_i,
	input  wire [3:0] hs_en_i,
	input  wire [3:0] cs_hs_sel_i,
	input  wire       cs_timer_sel_i,
	input  wire       cw_timer_sel_i,
	input  wire       can_en_i,
	// Status and controls out
	output reg  [2:0] mode_select_field_o,
	output reg        strap_level_bit_o,
	output reg        fail_cnt_sel_o,
	output reg        dev_mode_o,
	output reg        por_flag_o,
	output reg        overvoltage_flag_o,
	output reg        undervoltage_flag_o,
	output reg        wd_fail_flag_o,
	output reg        aux_reg_en_o,
	output reg  [3:0] hs_en_o,
	output reg  [3:0] cs_hs_sel_o,
	output reg        cs_timer_sel_o,
	output reg        cw_timer_sel_o,
	output reg  [1:0] can_mode_o
);
	localparam [5:0] ST_INIT = 6'h01;
	localparam [5:0] ST_NORM = 6'h02;
	localparam [5:0] ST_REST = 6'h04;
	localparam [5:0] ST_FAIL = 6'h08;
	localparam [5:0] ST_OFF  = 6'h10;
	localparam [5:0] ST_RDLY = 6'h20;

	reg [5:0]  st_q;
	reg [5:0]  st_d;
	reg [31:0] wd_cnt_q;
	reg [15:0] dly_q;
	reg        from_rest_q;
	reg        cfg_valid_q;
	reg        wd_fails_q;
	reg        fo_lat_q;
	reg        irq_s1_q;
	reg        irq_s2_q;
	reg        dbg_s1_q;
	reg        dbg_s2_q;
	reg        ov_s1_q;
	reg        ov_s2_q;
	reg        ov_prev_q;
	wire       strap_hi;
	wire       ov_rise;
	reg        req_fail;
	reg        req_rest;
	reg        fo_set;

	// Pins pass two flops before any logic sees them.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			dbg_s1_q <= 1'b1;
			dbg_s2_q <= 1'b1;
			ov_s1_q  <= 1'b0;
			ov_s2_q  <= 1'b0;
		end
		else
		begin
			irq_s1_q <= irq_pin_i;
			irq_s2_q <= irq_s1_q;
			dbg_s1_q <= debug_strap_pin_i;
			dbg_s2_q <= dbg_s1_q;
			ov_s1_q  <= main_reg_ov_i;
			ov_s2_q  <= ov_s1_q;
		end
	end

	// Filter restarts each reset delay window.
	sic_strap_filter
	#(
		.CNT_W    (16),
		.FILT_CYC (CFG_FILT_CYC)
	)
	u_filt
	(
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.clr_i       (st_q != ST_RDLY),
		.lvl_i       (irq_s2_q),
		.stable_hi_o (strap_hi)
	);

	assign ov_rise = ov_s2_q & ~ov_prev_q;

	// Weak pull-down only while the reset delay runs.
	assign irq_oe_n_o = ~((st_q == ST_RDLY) | irq_o);

	// Reaction to watchdog failure and overvoltage, as request pulses.
	always @*
	begin
		req_fail = 1'b0;
		req_rest = 1'b0;
		fo_set   = 1'b0;
		if (st_q == ST_NORM || st_q == ST_INIT)
		begin
			if (wd_fail_i && !dev_mode_o)
			begin
				fo_set = fail_cnt_sel_o | wd_fails_q;
				if (strap_level_bit_o)
					req_rest = 1'b1;
				else if (!fail_cnt_sel_o && !wd_fails_q)
					req_rest = 1'b1;
				else
					req_fail = 1'b1;
			end
			if (ov_rise && overvoltage_reset_enable_i)
			begin
				fo_set = 1'b1;
				if (strap_level_bit_o)
					req_rest = 1'b1;
				else
					req_fail = 1'b1;
			end
			if (req_fail)
				req_rest = 1'b0;
		end
	end

	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_OFF:
				if (por_ok_i && main_reg_ok_i)
					st_d = ST_RDLY;
			ST_RDLY:
				if (!main_reg_ok_i)
					st_d = ST_OFF;
				else if (dly_q == RST_DELAY_CYC - 1'b1)
					st_d = from_rest_q ? ST_NORM : ST_INIT;
			ST_INIT:
				if (req_fail)
					st_d = ST_FAIL;
				else if (req_rest)
					st_d = ST_REST;
				else if (!dev_mode_o && wd_cnt_q == LONG_WIN_CYC - 1)
					st_d = ST_REST;
				else if (cmd_rx_i)
					st_d = ST_NORM;
			ST_NORM:
				if (req_fail)
					st_d = ST_FAIL;
				else if (req_rest)
					st_d = ST_REST;
			ST_REST:
				st_d = ST_RDLY;
			ST_FAIL:
				if (wake_evt_i)
					st_d = ST_REST;
			default:
				st_d = ST_OFF;
		endcase
		if (!por_ok_i)
			st_d = ST_OFF;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q                <= ST_OFF;
			dly_q               <= 16'h0000;
			wd_cnt_q            <= 32'h00000000;
			from_rest_q         <= 1'b0;
			cfg_valid_q         <= 1'b0;
			wd_fails_q          <= 1'b0;
			fo_lat_q            <= 1'b0;
			ov_prev_q           <= 1'b0;
			reset_output_pin_o  <= 1'b0;
			strap_level_bit_o   <= 1'b0;
			fail_cnt_sel_o      <= 1'b0;
			dev_mode_o          <= 1'b0;
			por_flag_o          <= 1'b0;
			overvoltage_flag_o  <= 1'b0;
			undervoltage_flag_o <= 1'b0;
			wd_fail_flag_o      <= 1'b0;
			fail_outputs_o      <= 1'b0;
			irq_o               <= 1'b0;
			mode_select_field_o <= `SIC_MODE_INIT;
			aux_reg_en_o        <= 1'b0;
			hs_en_o             <= 4'h0;
			cs_hs_sel_o         <= 4'h0;
			cs_timer_sel_o      <= 1'b0;
			cw_timer_sel_o      <= 1'b0;
			can_mode_o          <= `SIC_CAN_OFF;
		end
		else
		begin
			st_q      <= st_d;
			ov_prev_q <= ov_s2_q;
			irq_o     <= 1'b0;
			fail_cnt_sel_o <= fail_cnt_sel_i;
			fo_lat_q       <= fo_lat_q | fo_set;
			dly_q <= (st_q == ST_RDLY) ? dly_q + 1'b1 : 16'h0000;
			reset_output_pin_o <= (st_d == ST_INIT) | (st_d == ST_NORM);
			if (st_q == ST_OFF)
			begin
				// Power was lost: configuration may be relearned.
				cfg_valid_q    <= 1'b0;
				por_flag_o     <= 1'b1;
				from_rest_q    <= 1'b0;
				fail_outputs_o <= 1'b0;
				wd_fails_q     <= 1'b0;
				fo_lat_q       <= 1'b0;
			end
			if (st_q == ST_RDLY && st_d != ST_RDLY && st_d != ST_OFF)
			begin
				if (!cfg_valid_q || por_flag_o)
				begin
					strap_level_bit_o <= strap_hi;
					cfg_valid_q       <= 1'b1;
				end
				if (!from_rest_q)
					dev_mode_o <= ~dbg_s2_q;
			end
			if (por_flag_clr_i && st_q != ST_OFF)
				por_flag_o <= 1'b0;
			// Watchdog long window runs only in Init; it restarts at each release into Init.
			if (st_q != ST_INIT || dev_mode_o)
				wd_cnt_q <= 32'h00000000;
			else
				wd_cnt_q <= wd_cnt_q + 1'b1;
			if (st_q == ST_INIT && wd_trigger_i)
				wd_cnt_q <= 32'h00000000;
			if (st_q == ST_INIT && st_d == ST_REST && !req_rest)
				wd_fail_flag_o <= 1'b1;
			if (req_fail || req_rest)
			begin
				wd_fails_q     <= wd_fail_i | wd_fails_q;
				wd_fail_flag_o <= wd_fail_i | wd_fail_flag_o;
			end
			if (fo_set)
				fail_outputs_o <= 1'b1;
			else if (st_q == ST_NORM && !fo_lat_q)
				fail_outputs_o <= fail_output_test_enable_i;
			// Set wins over software clear.
			if (ov_rise && st_q != ST_OFF && st_q != ST_RDLY)
				overvoltage_flag_o <= 1'b1;
			else if (ov_flag_clr_i)
				overvoltage_flag_o <= 1'b0;
			undervoltage_flag_o <= (st_q == ST_NORM) & ~main_reg_ok_i;
			if (st_q == ST_NORM && wake_evt_i)
				irq_o <= 1'b1;
			case (st_d)
				ST_REST:
				begin
					mode_select_field_o <= `SIC_MODE_RESTART;
					from_rest_q         <= 1'b1;
					hs_en_o             <= 4'h0;
					aux_reg_en_o        <= 1'b0;
					if (can_mode_o == `SIC_CAN_OFF)
						can_mode_o <= `SIC_CAN_OFF;
					else
						can_mode_o <= `SIC_CAN_WAKE;
				end
				ST_FAIL:
				begin
					mode_select_field_o <= `SIC_MODE_FAILSAFE;
					hs_en_o             <= 4'h0;
					aux_reg_en_o        <= 1'b0;
				end
				ST_INIT:
				begin
					mode_select_field_o <= `SIC_MODE_INIT;
					can_mode_o          <= `SIC_CAN_OFF;
					aux_reg_en_o        <= 1'b0;
					hs_en_o             <= 4'h0;
				end
				ST_NORM:
				begin
					if (st_q != ST_NORM)
						mode_select_field_o <= `SIC_MODE_NORMAL;
					else if (cmd_mode_wr_i)
						mode_select_field_o <= cmd_mode_i;
					else
					begin
						aux_reg_en_o   <= aux_reg_en_i;
						hs_en_o        <= hs_en_i;
						cs_hs_sel_o    <= cs_hs_sel_i;
						cs_timer_sel_o <= cs_timer_sel_i;
						cw_timer_sel_o <= cw_timer_sel_i;
						if (can_en_i)
							can_mode_o <= 2'h2;
						else
							can_mode_o <= `SIC_CAN_OFF;
					end
				end
				default:
					mode_select_field_o <= mode_select_field_o;
			endcase
		end
	end
endmodule // sic_init_ctrl
`default_nettype wire

/* tb/sic_init_ctrl_properties.sv */
// Purpose: Port-level checks of the start-up and mode control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Mode codes are 0 normal, 3 restart, 4 fail-safe, 5 init.
`timescale 1ns/1ns
`default_nettype none
module sic_init_ctrl_properties
(
	// Watched ports
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       por_ok_i,
	input wire logic       main_reg_ok_i,
	input wire logic       main_reg_ov_i,
	input wire logic       cmd_rx_i,
	input wire logic       cmd_mode_wr_i,
	input wire logic       wd_fail_i,
	input wire logic       wake_evt_i,
	input wire logic       fail_output_test_enable_i,
	input wire logic       irq_o,
	input wire logic       irq_oe_n_o,
	input wire logic       reset_output_pin_o,
	input wire logic       fail_outputs_o,
	input wire logic [2:0] mode_select_field_o,
	input wire logic       strap_level_bit_o,
	input wire logic       fail_cnt_sel_o,
	input wire logic       dev_mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic [2:0] md = mode_select_field_o;
	// Powered, released and free of software mode writes.
	wire logic run = por_ok_i & main_reg_ok_i & reset_output_pin_o
		& !cmd_mode_wr_i;
	a_init_cmd: assert property (run && md == 3'h5 && cmd_rx_i
		&& !wd_fail_i |=> md == 3'h0) else $error("init kept");
	a_init_wake: assert property (run && md == 3'h5 && wake_evt_i
		&& !cmd_rx_i |=> !irq_o) else $error("init wake reported");
	a_norm_wake: assert property (run && md == 3'h0 && wake_evt_i
		&& !wd_fail_i |=> irq_o && md == 3'h0) else $error("no wake irq");
	a_reg_low: assert property (!main_reg_ok_i
		|=> !reset_output_pin_o) else $error("reset released early");
	a_strap_hold: assert property (!$rose(reset_output_pin_o)
		&& $past(por_ok_i) |-> $stable(strap_level_bit_o))
		else $error("strap changed");
	a_pull_down: assert property ($rose(reset_output_pin_o)
		|-> $past(irq_oe_n_o) == 1'b0) else $error("no pull-down");
	a_wd_restart: assert property (run && md == 3'h0 && wd_fail_i
		&& strap_level_bit_o && !dev_mode_o
		|=> md == 3'h3 && !reset_output_pin_o) else $error("no restart");
	a_wd_failsafe: assert property (run && md == 3'h0 && wd_fail_i
		&& !strap_level_bit_o && fail_cnt_sel_o && !dev_mode_o
		|=> md == 3'h4) else $error("no fail-safe");
	a_fo_test: assert property (run && md == 3'h0 && !wd_fail_i
		&& fail_output_test_enable_i && !fail_outputs_o
		|-> ##[1:2] fail_outputs_o) else $error("fail test ignored");
	c_release: cover property ($rose(reset_output_pin_o));
	c_restart: cover property (md == 3'h3);
	c_irq: cover property (irq_o);
endmodule // sic_init_ctrl_properties
bind sic_init_ctrl sic_init_ctrl_properties chk_u (.clk_i, .rst_i,
	.por_ok_i, .main_reg_ok_i, .main_reg_ov_i, .cmd_rx_i, .cmd_mode_wr_i,
	.wd_fail_i, .wake_evt_i, .fail_output_test_enable_i, .irq_o,
	.irq_oe_n_o, .reset_output_pin_o, .fail_outputs_o,
	.mode_select_field_o, .strap_level_bit_o, .fail_cnt_sel_o, .dev_mode_o);
`default_nettype wire

/* tb/sic_host_model.sv */
// Purpose: Host side of the irq pin, with or without an external pull-up.
// Assumes: Pin level is resolved here and fed back to the block.
// Notes:   An undriven pin without pull-up toggles every cycle.
`timescale 1ns/1ns
`default_nettype none
module sic_host_model
(
	// Pin
	input  wire logic clk_i,
	input  wire logic pull_up_i,
	input  wire logic irq_o_i,
	input  wire logic irq_oe_n_i,
	output var logic  irq_pin_o
);
	logic tog_q = 1'b0;
	always @(posedge clk_i)
		tog_q <= ~tog_q;
	// The strong pull-up beats the weak internal pull-down.
	assign irq_pin_o = pull_up_i ? 1'b1 : (irq_oe_n_i ? tog_q : irq_o_i);
endmodule // sic_host_model
`default_nettype wire

/* tb/sbc_init_config_mode_ctrl_test.sv */
// Purpose: Self-checking bench of the start-up and mode control block.
// Assumes: Shortened counts: window 200, delay 20, filter 5 cycles.
// Notes:   Each power-up random-picks the fail count and side controls.
`timescale 1ns/1ns
`default_nettype none
module sbc_init_config_mode_ctrl_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        por_q = 1'b0;
	logic        reg_q = 1'b0;
	logic        ov_q = 1'b0;
	logic        fot_q = 1'b0;
	logic        cnt_q = 1'b0;
	logic        pull_q = 1'b1;
	logic        dbg_q = 1'b1;
	logic [6:0]  pls_q = 7'h00;
	logic [15:0] rnd_q = 16'h0;
	logic        pin, irq, oe_n, ro, fo, strap;
	logic [2:0]  mode;
	logic        por_f, ov_f, uv_f, wdf_f, dev, fcs, aux, cst, cwt;
	logic [3:0]  hs, cs;
	logic [1:0]  can;
	int          err_count = 0;
	int          n_compared = 0;
	int          exp_mode;
	sic_host_model host_u (.clk_i(clk_i), .pull_up_i(pull_q),
		.irq_o_i(irq), .irq_oe_n_i(oe_n), .irq_pin_o(pin));
	sic_init_ctrl #(.LONG_WIN_CYC(32'd200), .RST_DELAY_CYC(16'd20),
		.CFG_FILT_CYC(16'd5)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.por_ok_i(por_q), .main_reg_ok_i(reg_q), .main_reg_ov_i(ov_q),
		.irq_pin_i(pin), .debug_strap_pin_i(dbg_q), .irq_o(irq),
		.irq_oe_n_o(oe_n), .reset_output_pin_o(ro), .fail_outputs_o(fo),
		.cmd_rx_i(pls_q[0]), .cmd_mode_wr_i(pls_q[3]),
		.cmd_mode_i(rnd_q[14:12]), .wd_trigger_i(pls_q[4]),
		.wd_fail_i(pls_q[1]), .wake_evt_i(pls_q[2]),
		.por_flag_clr_i(pls_q[5]), .fail_cnt_sel_i(cnt_q),
		.overvoltage_reset_enable_i(rnd_q[15]),
		.fail_output_test_enable_i(fot_q), .ov_flag_clr_i(pls_q[6]),
		.aux_reg_en_i(rnd_q[0]), .hs_en_i(rnd_q[4:1]),
		.cs_hs_sel_i(rnd_q[8:5]), .cs_timer_sel_i(rnd_q[9]),
		.cw_timer_sel_i(rnd_q[10]), .can_en_i(rnd_q[11]),
		.mode_select_field_o(mode), .strap_level_bit_o(strap),
		.fail_cnt_sel_o(fcs), .dev_mode_o(dev), .por_flag_o(por_f),
		.overvoltage_flag_o(ov_f), .undervoltage_flag_o(uv_f),
		.wd_fail_flag_o(wdf_f), .aux_reg_en_o(aux), .hs_en_o(hs),
		.cs_hs_sel_o(cs), .cs_timer_sel_o(cst), .cw_timer_sel_o(cwt),
		.can_mode_o(can));
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(input logic [6:0] p);
		@(posedge clk_i);
		pls_q <= p;
		@(posedge clk_i);
		pls_q <= 7'h00;
		@(negedge clk_i);
	endtask
	// Bounded wait; a miss shows up in the following compare.
	task automatic wt(input logic [2:0] m, input logic r);
		int n;
		n = 0;
		while ((mode !== m || ro !== r) && n < 500)
		begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic pwr(input logic p);
		@(posedge clk_i);
		por_q <= 1'b0;
		reg_q <= 1'b0;
		pull_q <= p;
		{cnt_q, rnd_q} <= 17'($urandom);
		repeat (3) @(posedge clk_i);
		por_q <= 1'b1;
		reg_q <= 1'b1;
		wt(3'h5, 1'b1);
	endtask
	task automatic level(input logic v);
		@(posedge clk_i);
		fot_q <= v;
		repeat (3) @(negedge clk_i);
		chk("fail_out", {2'h0, v}, {2'h0, fo});
	endtask
	initial
		forever #25 clk_i = ~clk_i;
	initial
	begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		wrap_up();
	end
	initial
	begin
		void'($urandom(1749));
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		chk("mode", 3'h5, mode);
		@(posedge clk_i);
		rst_i <= 1'b0;
		pwr(1'b1);
		chk("strap", 3'h1, {2'h0, strap});
		pulse(3'h4);
		chk("irq", 3'h0, {2'h0, irq});
		// No trigger is sent, so the long window must run out.
		wt(3'h3, 1'b0);
		chk("mode", 3'h3, mode);
		chk("wd_flag", 8'h1, {7'h0, wdf_f});
		wt(3'h0, 1'b1);
		chk("mode", 3'h0, mode);
		chk("strap", 3'h1, {2'h0, strap});
		chk("can", 8'h0, {6'h0, can});
		chk("hs", 8'h0, {4'h0, hs});
		pulse(3'h2);
		chk("mode", 3'h3, mode);
		chk("fail_out", {7'h0, cnt_q}, {7'h0, fo});
		chk("cnt_sel", {7'h0, cnt_q}, {7'h0, fcs});
		wt(3'h0, 1'b1);
		@(posedge clk_i);
		ov_q <= 1'b1;
		repeat (6) @(negedge clk_i);
		exp_mode = rnd_q[15] ? 3 : 0;
		chk("mode", 3'(exp_mode), mode);
		chk("ov_flag", 8'h1, {7'h0, ov_f});
		chk("fail_out", {7'h0, cnt_q | rnd_q[15]}, {7'h0, fo});
		@(posedge clk_i);
		ov_q <= 1'b0;
		pulse(7'h40);
		chk("ov_flag", 8'h0, {7'h0, ov_f});
		$display("test pull-up done");
		pwr(1'b0);
		chk("strap", 3'h0, {2'h0, strap});
		chk("por_flag", 8'h1, {7'h0, por_f});
		chk("dev", 8'h0, {7'h0, dev});
		pulse(7'h20);
		chk("por_flag", 8'h0, {7'h0, por_f});
		// A trigger late in the window must start it afresh.
		repeat (150) @(posedge clk_i);
		pulse(7'h10);
		repeat (100) @(negedge clk_i);
		chk("mode", 3'h5, mode);
		pulse(3'h1);
		chk("mode", 3'h0, mode);
		pulse(3'h4);
		chk("irq", 3'h1, {2'h0, irq});
		level(1'b1);
		level(1'b0);
		chk("hs", {4'h0, rnd_q[4:1]}, {4'h0, hs});
		chk("cs_sel", {2'h0, rnd_q[10:5]}, {2'h0, cwt, cst, cs});
		chk("aux_can", {5'h0, rnd_q[11], 1'b0, rnd_q[0]},
			{5'h0, can, aux});
		chk("uv_flag", 8'h0, {7'h0, uv_f});
		pulse(7'h08);
		chk("mode", {5'h0, rnd_q[14:12]}, mode);
		pulse(3'h2);
		exp_mode = cnt_q ? 4 : 3;
		chk("mode", 3'(exp_mode), mode);
		chk("fail_out", {7'h0, cnt_q}, {7'h0, fo});
		$display("test no pull-up done");
		@(posedge clk_i);
		dbg_q <= 1'b0;
		pwr(1'b0);
		chk("dev", 8'h1, {7'h0, dev});
		repeat (250) @(negedge clk_i);
		chk("mode", 3'h5, mode);
		pulse(3'h2);
		chk("mode", 3'h5, mode);
		$display("test debug strap done");
		wrap_up();
	end
endmodule // sbc_init_config_mode_ctrl_test
`default_nettype wire
